// ### rtl/asd_decoder.sv
// address space decoder: target selection, fill values, information overlay
//
// Contract
// - top 256 bytes F00h-FFFh decode as control registers, apart from RAM
// - 512 bytes of RAM start at 000h; contents after reset undefined
// - reads of reserved control addresses return an undefined value
// - addresses 200h-EFFh read undefined, writes change nothing
// - flash up to 16 KB; reads beyond implemented flash return FFh
// - writes to unimplemented program addresses are ignored
// - option, reset, exception, interrupt vectors, then code, at fixed ranges
// - the 64 KB data space has no target at all
// - information area reachable only while page-select bit 7 is 1
// - enabled overlay: constant loads at FE00h-FFFFh read information bytes
// - enabled overlay: debugger reads there also read information bytes
// - instruction fetches there always read program memory
// - information area is read only; writes leave it unchanged
// - part number string at FE40h-FE5Fh, zero padded; rest reserved
// - F00-F09 select timer 0 group; F0A-F1F reserved
// - F20-F29 and F2C-F3B select modulator group; F2A, F2B, F3C-F3F reserved
`timescale 1ns/1ps

module asd_decoder
  import asd_pkg::*;
#(
  parameter int          FLASH_BYTES = 16384,
  // arbitrary sample part number, 20 characters
  parameter logic [159:0] PART_NUMBER = "DECODER-SAMPLE-0001A"
)(
  // clock and reset
  input  wire logic           mclk,
  input  wire logic           arst_n,
  // access from core or debugger
  input  wire asd_req_type    req,
  input  wire logic [7:0]     info_page_sel,
  // read data from targets, valid while their select is high
  input  wire logic [7:0]     ram_rdata,
  input  wire logic [7:0]     tmr_rdata,
  input  wire logic [7:0]     pwm_rdata,
  input  wire logic [7:0]     periph_rdata,
  input  wire logic [7:0]     flash_rdata,
  // target selects and shared address/data
  output asd_state_type       st_unused_n,
  output logic                ram_sel,
  output logic                tmr_sel,
  output logic                pwm_sel,
  output logic                periph_sel,
  output logic                flash_sel,
  output logic                wr_en,
  output logic [11:0]         rf_addr,
  output logic [15:0]         pm_addr,
  output logic [7:0]          wdata,
  output asd_region_type      region,
  // read answer
  output logic                rd_valid,
  output logic [7:0]          rdata
);

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  localparam int PN_BITS = PN_CHARS * 8;

  if (FLASH_BYTES < 64 || FLASH_BYTES > 16384 || (FLASH_BYTES & (FLASH_BYTES - 1)) != 0)
  begin : g_bad_flash
    $error("FLASH_BYTES must be a power of two from 64 to 16384");
  end

  localparam logic [16:0] FLASH_LIMIT = 17'(FLASH_BYTES);

  // ------------------------------------------------------------------
  // part number table
  // ------------------------------------------------------------------
  logic [7:0] pn_rom [PN_BYTES];

  for (genvar i = 0; i < PN_BYTES; i++)
  begin : g_pn
    if (i < PN_CHARS)
    begin : g_chr
      assign pn_rom[i] = PART_NUMBER[PN_BITS - 1 - 8 * i -: 8];
    end
    else
    begin : g_pad
      assign pn_rom[i] = 8'h00;
    end
  end

  // ------------------------------------------------------------------
  // request decode
  // ------------------------------------------------------------------
  asd_state_type st_q;
  asd_state_type st_d;
  logic [11:0]   ra;
  logic [15:0]   pa;
  logic          is_reg;
  logic          is_prog;
  logic          info_on;
  logic          overlay;
  logic [8:0]    info_off;

  assign ra       = req.addr[11:0];
  assign pa       = req.addr;
  assign is_reg   = req.valid && req.space == SP_REG;
  assign is_prog  = req.valid && req.space == SP_PROG;
  assign info_on  = info_page_sel[INFO_EN_BIT];
  assign info_off = pa[8:0];
  // fetches never see the overlay, only data reads do
  assign overlay  = info_on && pa >= INFO_BASE && req.kind != AK_FETCH;

  always_comb
  begin
    st_d            = st_q;
    st_d.ram_sel    = 1'b0;
    st_d.tmr_sel    = 1'b0;
    st_d.pwm_sel    = 1'b0;
    st_d.periph_sel = 1'b0;
    st_d.flash_sel  = 1'b0;
    st_d.wr_en      = 1'b0;
    st_d.src        = SRC_NONE;
    st_d.rd_valid   = 1'b0;

    // answer for the read issued last cycle
    if (st_q.src != SRC_NONE)
    begin
      st_d.rd_valid = 1'b1;
      case (st_q.src)
        SRC_RAM:    st_d.rdata = ram_rdata;
        SRC_TMR:    st_d.rdata = tmr_rdata;
        SRC_PWM:    st_d.rdata = pwm_rdata;
        SRC_PERIPH: st_d.rdata = periph_rdata;
        SRC_FLASH:  st_d.rdata = flash_rdata;
        SRC_INFO:   st_d.rdata = st_q.info_byte;
        SRC_FILL:   st_d.rdata = FLASH_FILL;
        default:    st_d.rdata = UNDEF_DATA;
      endcase
    end

    if (req.valid)
    begin
      st_d.wr_en   = req.write;
      st_d.rf_addr = ra;
      st_d.pm_addr = pa;
      st_d.wdata   = req.wdata;
    end

    // only one branch of this chain can set a select
    if (is_reg)
    begin
      if (ra <= RF_RAM_LAST)
      begin
        st_d.ram_sel = 1'b1;
        st_d.src     = SRC_RAM;
      end
      else if (ra < RF_CTRL_FIRST)
        st_d.src = SRC_UNDEF;
      else if (ra <= RF_TMR_LAST)
      begin
        st_d.tmr_sel = 1'b1;
        st_d.src     = SRC_TMR;
      end
      else if ((ra >= RF_PWM_A_FST && ra <= RF_PWM_A_LST)
            || (ra >= RF_PWM_B_FST && ra <= RF_PWM_B_LST))
      begin
        st_d.pwm_sel = 1'b1;
        st_d.src     = SRC_PWM;
      end
      else if (ra >= RF_PERIPH_FST)
      begin
        st_d.periph_sel = 1'b1;
        st_d.src        = SRC_PERIPH;
      end
      else
        // reserved holes: no target, so a stray write has nowhere to land
        st_d.src = SRC_UNDEF;
    end
    else if (is_prog)
    begin
      if (overlay)
        st_d.src = SRC_INFO;
      else if ({1'b0, pa} < FLASH_LIMIT)
      begin
        st_d.flash_sel = 1'b1;
        st_d.src       = SRC_FLASH;
      end
      else
        st_d.src = SRC_FILL;
      if (info_off >= PN_FIRST && info_off <= PN_LAST)
        st_d.info_byte = pn_rom[5'(info_off - PN_FIRST)];
      else
        st_d.info_byte = UNDEF_DATA;
    end
    else if (req.valid)
      st_d.src = SRC_UNDEF;

    if (req.valid && req.write)
      st_d.src = SRC_NONE;

    if (is_prog)
    begin
      if (pa <= PM_OPTION_LAST)
        st_d.region = PR_OPTION;
      else if (pa <= PM_RESET_LAST)
        st_d.region = PR_RESET_VEC;
      else if (pa <= PM_EXCEPT_LAST)
        st_d.region = PR_EXCEPT_VEC;
      else if (pa <= PM_INT_LAST)
        st_d.region = PR_INT_VEC;
      else if (pa <= PM_CODE_LAST)
        st_d.region = PR_CODE;
      else
        st_d.region = PR_BEYOND;
    end
    else if (req.valid)
      st_d.region = PR_NONE;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign st_unused_n = st_q;
  assign ram_sel     = st_q.ram_sel;
  assign tmr_sel     = st_q.tmr_sel;
  assign pwm_sel     = st_q.pwm_sel;
  assign periph_sel  = st_q.periph_sel;
  assign flash_sel   = st_q.flash_sel;
  assign wr_en       = st_q.wr_en;
  assign rf_addr     = st_q.rf_addr;
  assign pm_addr     = st_q.pm_addr;
  assign wdata       = st_q.wdata;
  assign region      = st_q.region;
  assign rd_valid    = st_q.rd_valid;
  assign rdata       = st_q.rdata;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  logic any_sel;
  assign any_sel = ram_sel | tmr_sel | pwm_sel | periph_sel | flash_sel;

  one_target_a: assert property (
    $onehot0({ram_sel, tmr_sel, pwm_sel, periph_sel, flash_sel}))
    else $error("two targets selected at once");

  ram_decode_a: assert property (
    req.valid && req.space == SP_REG && req.addr[11:0] <= RF_RAM_LAST
    |=> ram_sel && rf_addr == $past(req.addr[11:0]))
    else $error("ram not selected for low register address");

  gap_quiet_a: assert property (
    req.valid && req.space == SP_REG && req.addr[11:0] > RF_RAM_LAST
    && req.addr[11:0] < RF_CTRL_FIRST && !req.write
    |=> !any_sel ##1 rd_valid && rdata == UNDEF_DATA)
    else $error("gap address reached a target");

  ctrl_group_a: assert property (
    req.valid && req.space == SP_REG && req.addr[11:0] >= RF_CTRL_FIRST
    |=> !ram_sel)
    else $error("control address selected ram");

  timer_group_a: assert property (
    req.valid && req.space == SP_REG && req.addr[11:0] >= RF_CTRL_FIRST
    && req.addr[11:0] <= RF_TMR_LAST |=> tmr_sel && !pwm_sel)
    else $error("timer group not selected");

  pwm_group_a: assert property (
    req.valid && req.space == SP_REG && req.addr[11:0] >= RF_PWM_B_FST
    && req.addr[11:0] <= RF_PWM_B_LST |=> pwm_sel)
    else $error("modulator group not selected");

  ctrl_hole_a: assert property (
    req.valid && req.space == SP_REG && req.addr[11:0] > RF_PWM_A_LST
    && req.addr[11:0] < RF_PWM_B_FST |=> !any_sel)
    else $error("reserved control address selected a target");

  flash_fill_a: assert property (
    req.valid && req.space == SP_PROG && !req.write && {1'b0, req.addr} >= FLASH_LIMIT
    && !(info_page_sel[INFO_EN_BIT] && req.addr >= INFO_BASE)
    |=> !flash_sel ##1 rd_valid && rdata == FLASH_FILL)
    else $error("unimplemented program read did not return fill");

  beyond_write_a: assert property (
    req.valid && req.space == SP_PROG && req.write && {1'b0, req.addr} >= FLASH_LIMIT
    |=> !any_sel)
    else $error("write beyond flash reached a target");

  vector_region_a: assert property (
    req.valid && req.space == SP_PROG && req.addr > PM_EXCEPT_LAST && req.addr <= PM_INT_LAST
    |=> region == PR_INT_VEC)
    else $error("interrupt vector range misclassified");

  data_space_a: assert property (
    req.valid && req.space == SP_DATA && !req.write
    |=> !any_sel ##1 rd_valid && rdata == UNDEF_DATA)
    else $error("data space access reached a target");

  info_load_a: assert property (
    req.valid && req.space == SP_PROG && !req.write && info_page_sel[INFO_EN_BIT]
    && req.kind == AK_CONSTANT_LOAD && req.addr == INFO_BASE + 16'h0040
    |=> !flash_sel ##1 rd_valid && rdata == PART_NUMBER[PN_BITS - 1 -: 8])
    else $error("constant load missed information area");

  info_debug_pad_a: assert property (
    req.valid && req.space == SP_PROG && !req.write && info_page_sel[INFO_EN_BIT]
    && req.kind == AK_DEBUG && req.addr == INFO_BASE + 16'h0055
    |=> ##1 rd_valid && rdata == 8'h00)
    else $error("debugger read of padding not zero");

  fetch_flash_a: assert property (
    req.valid && req.space == SP_PROG && !req.write && req.kind == AK_FETCH
    && req.addr >= INFO_BASE |=> ##1 rd_valid && rdata == FLASH_FILL)
    else $error("fetch saw the information area");

  info_ro_a: assert property (
    req.valid && req.space == SP_PROG && req.write && req.addr >= INFO_BASE
    |=> !flash_sel ##1 !rd_valid)
    else $error("write to information area took effect");

endmodule

// ### rtl/asd_pkg.sv
// address space decoder: shared types and address constants
package asd_pkg;

  // ------------------------------------------------------------------
  // access request
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    SP_REG  = 2'h0,
    SP_PROG = 2'h1,
    SP_DATA = 2'h2
  } asd_space_type;

  typedef enum logic [1:0] {
    AK_FETCH                       = 2'h0,
    AK_CONSTANT_LOAD               = 2'h1,
    AK_CONSTANT_LOAD_AUTOINCREMENT = 2'h2,
    AK_DEBUG                       = 2'h3
  } asd_kind_type;

  typedef struct packed {
    logic          valid;
    asd_space_type space;
    asd_kind_type  kind;
    logic          write;
    logic [15:0]   addr;
    logic [7:0]    wdata;
  } asd_req_type;

  // ------------------------------------------------------------------
  // read source and program region codes
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    SRC_NONE   = 4'h0,
    SRC_RAM    = 4'h1,
    SRC_TMR    = 4'h2,
    SRC_PWM    = 4'h3,
    SRC_PERIPH = 4'h4,
    SRC_FLASH  = 4'h5,
    SRC_INFO   = 4'h6,
    SRC_FILL   = 4'h7,
    SRC_UNDEF  = 4'h8
  } asd_src_type;

  typedef enum logic [2:0] {
    PR_NONE       = 3'h0,
    PR_OPTION     = 3'h1,
    PR_RESET_VEC  = 3'h2,
    PR_EXCEPT_VEC = 3'h3,
    PR_INT_VEC    = 3'h4,
    PR_CODE       = 3'h5,
    PR_BEYOND     = 3'h6
  } asd_region_type;

  // ------------------------------------------------------------------
  // register file map
  // ------------------------------------------------------------------
  localparam logic [11:0] RF_RAM_LAST   = 12'h1FF;
  localparam logic [11:0] RF_CTRL_FIRST = 12'hF00;
  localparam logic [11:0] RF_TMR_LAST   = 12'hF09;
  localparam logic [11:0] RF_PWM_A_FST  = 12'hF20;
  localparam logic [11:0] RF_PWM_A_LST  = 12'hF29;
  localparam logic [11:0] RF_PWM_B_FST  = 12'hF2C;
  localparam logic [11:0] RF_PWM_B_LST  = 12'hF3B;
  localparam logic [11:0] RF_PERIPH_FST = 12'hF40;

  // ------------------------------------------------------------------
  // program memory map and information area
  // ------------------------------------------------------------------
  localparam logic [15:0] PM_OPTION_LAST = 16'h0001;
  localparam logic [15:0] PM_RESET_LAST  = 16'h0003;
  localparam logic [15:0] PM_EXCEPT_LAST = 16'h0007;
  localparam logic [15:0] PM_INT_LAST    = 16'h003F;
  localparam logic [15:0] PM_CODE_LAST   = 16'h3FFF;
  localparam logic [15:0] INFO_BASE      = 16'hFE00;
  localparam logic [8:0]  PN_FIRST       = 9'h040;
  localparam logic [8:0]  PN_LAST        = 9'h05F;
  localparam int          PN_CHARS       = 20;
  localparam int          PN_BYTES       = 32;
  localparam int          INFO_EN_BIT    = 7;
  localparam logic [7:0]  FLASH_FILL     = 8'hFF;
  localparam logic [7:0]  UNDEF_DATA     = 8'h00;

  typedef struct packed {
    logic           ram_sel;
    logic           tmr_sel;
    logic           pwm_sel;
    logic           periph_sel;
    logic           flash_sel;
    logic           wr_en;
    logic [11:0]    rf_addr;
    logic [15:0]    pm_addr;
    logic [7:0]     wdata;
    asd_src_type    src;
    logic [7:0]     info_byte;
    asd_region_type region;
    logic           rd_valid;
    logic [7:0]     rdata;
  } asd_state_type;

endpackage

// ### verification/asd_target_model.sv
// target model: read data of RAM, timer, modulator, peripheral and flash
`timescale 1ns/1ps

module asd_target_model (
  // clock
  input  wire logic        mclk,
  // selects, strobe and shared address/data from the decoder
  input  wire logic        ram_sel,
  input  wire logic        tmr_sel,
  input  wire logic        pwm_sel,
  input  wire logic        periph_sel,
  input  wire logic        flash_sel,
  input  wire logic        wr_en,
  input  wire logic [11:0] rf_addr,
  input  wire logic [15:0] pm_addr,
  input  wire logic [7:0]  wdata,
  // read data back to the decoder
  output logic [7:0]       ram_rdata,
  output logic [7:0]       tmr_rdata,
  output logic [7:0]       pwm_rdata,
  output logic [7:0]       periph_rdata,
  output logic [7:0]       flash_rdata
);
  logic [7:0] ram_mem [0:511];
  logic [7:0] flash_byte;

  // ------------------------------------------------------------------
  // RAM: preloaded with a pattern, never cleared by reset
  // ------------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 512; i++)
      ram_mem[i] = 8'(i) ^ 8'hC3;
  end

  // plain always: the preload above also writes this array
  always @(posedge mclk)
  begin
    if (ram_sel && wr_en)
      ram_mem[rf_addr[8:0]] <= wdata;
  end

  // ------------------------------------------------------------------
  // read data
  // ------------------------------------------------------------------
  // unselected targets show the inverse, so a missing select cannot read right
  assign flash_byte   = pm_addr[7:0] ^ 8'h5A;
  assign ram_rdata    = ram_sel ? ram_mem[rf_addr[8:0]] : ~ram_mem[rf_addr[8:0]];
  assign tmr_rdata    = tmr_sel ? 8'h21 : 8'hDE;
  assign pwm_rdata    = pwm_sel ? 8'h32 : 8'hCD;
  assign periph_rdata = periph_sel ? 8'h43 : 8'hBC;
  assign flash_rdata  = flash_sel ? flash_byte : ~flash_byte;
endmodule

// ### verification/tb_top.sv
// testbench for the address space decoder
`timescale 1ns/1ps

module tb_top
  import asd_pkg::*;
;
  localparam logic [159:0] PN = "VERIFY-PART-NUMBER-9";

  logic           mclk;
  logic           arst_n;
  asd_req_type    req;
  logic [7:0]     info_page_sel;
  logic [7:0]     ram_rdata, tmr_rdata, pwm_rdata, periph_rdata, flash_rdata;
  logic           ram_sel, tmr_sel, pwm_sel, periph_sel, flash_sel, wr_en;
  logic [11:0]    rf_addr;
  logic [15:0]    pm_addr;
  logic [7:0]     wdata;
  asd_region_type region;
  logic           rd_valid;
  logic [7:0]     rdata;
  int             err_count;
  int             comparisons;
  logic [4:0]     s_sel;
  logic           s_we;
  asd_region_type s_rg;
  logic           s_rv;
  logic [7:0]     s_rd;

  asd_decoder #(.FLASH_BYTES(16384), .PART_NUMBER(PN)) dut (
    .mclk(mclk), .arst_n(arst_n), .req(req), .info_page_sel(info_page_sel),
    .ram_rdata(ram_rdata), .tmr_rdata(tmr_rdata), .pwm_rdata(pwm_rdata),
    .periph_rdata(periph_rdata), .flash_rdata(flash_rdata), .st_unused_n(),
    .ram_sel(ram_sel), .tmr_sel(tmr_sel), .pwm_sel(pwm_sel), .periph_sel(periph_sel),
    .flash_sel(flash_sel), .wr_en(wr_en), .rf_addr(rf_addr), .pm_addr(pm_addr),
    .wdata(wdata), .region(region), .rd_valid(rd_valid), .rdata(rdata));

  asd_target_model model (
    .mclk(mclk), .ram_sel(ram_sel), .tmr_sel(tmr_sel), .pwm_sel(pwm_sel),
    .periph_sel(periph_sel), .flash_sel(flash_sel), .wr_en(wr_en), .rf_addr(rf_addr),
    .pm_addr(pm_addr), .wdata(wdata), .ram_rdata(ram_rdata), .tmr_rdata(tmr_rdata),
    .pwm_rdata(pwm_rdata), .periph_rdata(periph_rdata), .flash_rdata(flash_rdata));

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      err_count++;
    end
  endtask

  // one access: selects sampled 1 ns after the taking edge, read answer one cycle later
  task automatic acc(input asd_space_type sp, input asd_kind_type k, input logic w,
                     input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{1'b1, sp, k, w, a, d};
    @(posedge mclk);
    req.valid <= 1'b0;
    #1;
    s_sel = {ram_sel, tmr_sel, pwm_sel, periph_sel, flash_sel};
    s_we  = wr_en;
    s_rg  = region;
    @(posedge mclk);
    #1;
    s_rv = rd_valid;
    s_rd = rdata;
  endtask

  task automatic wrap_up();
    if (err_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reg_map();
    logic [11:0] ra [18];
    logic [4:0]  rs [18];
    logic [7:0]  ed;
    ra = '{12'h000, 12'h1FF, 12'h200, 12'hEFF, 12'hF00, 12'hF09, 12'hF0A, 12'hF1F, 12'hF20,
           12'hF29, 12'hF2A, 12'hF2B, 12'hF2C, 12'hF3B, 12'hF3C, 12'hF3F, 12'hF40, 12'hFFF};
    rs = '{5'h10, 5'h10, 5'h00, 5'h00, 5'h08, 5'h08, 5'h00, 5'h00, 5'h04,
           5'h04, 5'h00, 5'h00, 5'h04, 5'h04, 5'h00, 5'h00, 5'h02, 5'h02};
    for (int i = 0; i < 18; i++)
    begin
      acc(SP_REG, AK_FETCH, 1'b0, {4'h0, ra[i]}, 8'h00);
      ed = rs[i] == 5'h10 ? ra[i][7:0] ^ 8'hC3 : rs[i] == 5'h08 ? 8'h21 :
           rs[i] == 5'h04 ? 8'h32 : rs[i] == 5'h02 ? 8'h43 : 8'h00;
      chk("reg select", 16'(s_sel), 16'(rs[i]));
      chk("reg read data", 16'(s_rd), 16'(ed));
      chk("reg read valid", 16'(s_rv), 16'h0001);
      chk("reg region", 16'(s_rg), 16'(PR_NONE));
    end
  endtask

  task automatic t_writes();
    acc(SP_REG, AK_FETCH, 1'b1, 16'h01FF, 8'h5A);
    chk("ram write select", 16'({s_sel, s_we}), 16'h0021);
    chk("write no answer", 16'(s_rv), 16'h0000);
    acc(SP_REG, AK_FETCH, 1'b1, 16'h0300, 8'hA5);
    chk("gap write select", 16'({s_sel, s_we}), 16'h0001);
    acc(SP_REG, AK_FETCH, 1'b1, 16'h0F03, 8'hA5);
    chk("ctrl write select", 16'({s_sel, s_we}), 16'h0011);
    acc(SP_REG, AK_FETCH, 1'b0, 16'h01FF, 8'h00);
    chk("ram readback", 16'(s_rd), 16'h005A);
    acc(SP_REG, AK_FETCH, 1'b0, 16'h0300, 8'h00);
    chk("gap read", 16'(s_rd), 16'h0000);
    acc(SP_DATA, AK_CONSTANT_LOAD, 1'b1, 16'h0010, 8'h77);
    chk("data write select", 16'(s_sel), 16'h0000);
    acc(SP_DATA, AK_CONSTANT_LOAD, 1'b0, 16'h0010, 8'h00);
    chk("data read select", 16'(s_sel), 16'h0000);
    chk("data read value", 16'(s_rd), 16'h0000);
    acc(SP_REG, AK_FETCH, 1'b0, 16'h0010, 8'h00);
    chk("ram after data write", 16'(s_rd), 16'h00D3);
  endtask

  task automatic t_program();
    logic [15:0]    pa [10];
    asd_region_type pr [10];
    pa = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0007,
           16'h0008, 16'h003F, 16'h0040, 16'h3FFF};
    pr = '{PR_OPTION, PR_OPTION, PR_RESET_VEC, PR_RESET_VEC, PR_EXCEPT_VEC,
           PR_EXCEPT_VEC, PR_INT_VEC, PR_INT_VEC, PR_CODE, PR_CODE};
    for (int i = 0; i < 10; i++)
    begin
      acc(SP_PROG, AK_FETCH, 1'b0, pa[i], 8'h00);
      chk("prog select", 16'(s_sel), 16'h0001);
      chk("prog region", 16'(s_rg), 16'(pr[i]));
      chk("prog data", 16'(s_rd), 16'(pa[i][7:0] ^ 8'h5A));
    end
    acc(SP_PROG, AK_CONSTANT_LOAD, 1'b0, 16'h4000, 8'h00);
    chk("beyond select", 16'(s_sel), 16'h0000);
    chk("beyond region", 16'(s_rg), 16'(PR_BEYOND));
    chk("beyond data", 16'(s_rd), 16'h00FF);
    acc(SP_PROG, AK_DEBUG, 1'b1, 16'h4000, 8'h12);
    chk("beyond write", 16'({s_sel, s_we, s_rv}), 16'h0002);
  endtask

  task automatic t_info();
    logic [7:0] ec;
    @(posedge mclk);
    info_page_sel <= 8'h7F;
    acc(SP_PROG, AK_CONSTANT_LOAD, 1'b0, 16'hFE40, 8'h00);
    chk("overlay off data", 16'(s_rd), 16'h00FF);
    @(posedge mclk);
    info_page_sel <= 8'h80;
    for (int i = 0; i < 32; i++)
    begin
      ec = i < 20 ? PN[159 - 8 * i -: 8] : 8'h00;
      acc(SP_PROG, i[0] ? AK_DEBUG : AK_CONSTANT_LOAD_AUTOINCREMENT, 1'b0, 16'hFE40 + 16'(i),
          8'h00);
      chk("part number byte", 16'(s_rd), 16'(ec));
      chk("overlay select", 16'(s_sel), 16'h0000);
    end
    acc(SP_PROG, AK_CONSTANT_LOAD, 1'b0, 16'hFE00, 8'h00);
    chk("reserved low", 16'(s_rd), 16'h0000);
    acc(SP_PROG, AK_DEBUG, 1'b0, 16'hFFFF, 8'h00);
    chk("reserved high", 16'(s_rd), 16'h0000);
    acc(SP_PROG, AK_FETCH, 1'b0, 16'hFE40, 8'h00);
    chk("fetch under overlay", 16'(s_rd), 16'h00FF);
    acc(SP_PROG, AK_DEBUG, 1'b1, 16'hFE40, 8'h00);
    chk("overlay write", 16'({s_sel, s_we, s_rv}), 16'h0002);
    acc(SP_PROG, AK_CONSTANT_LOAD, 1'b0, 16'hFE40, 8'h00);
    chk("overlay after write", 16'(s_rd), 16'(PN[159:152]));
    @(posedge mclk);
    info_page_sel <= 8'h00;
  endtask

  task automatic t_b2b();
    @(posedge mclk);
    req <= '{1'b1, SP_REG, AK_FETCH, 1'b0, 16'h0005, 8'h00};
    @(posedge mclk);
    req.addr <= 16'h0F01;
    #1;
    chk("b2b ram select", 16'(ram_sel), 16'h0001);
    @(posedge mclk);
    req.addr <= 16'h0F30;
    #1;
    chk("b2b timer select", 16'(tmr_sel), 16'h0001);
    chk("b2b ram data", 16'(rdata), 16'h00C6);
    @(posedge mclk);
    req.valid <= 1'b0;
    #1;
    chk("b2b pwm select", 16'({ram_sel, tmr_sel, pwm_sel}), 16'h0001);
    chk("b2b timer data", 16'(rdata), 16'h0021);
    @(posedge mclk);
    #1;
    chk("b2b pwm data", 16'(rdata), 16'h0032);
  endtask

  // ------------------------------------------------------------------
  // clock, reset, sequence and watchdog
  // ------------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial
  begin
    err_count     = 0;
    comparisons   = 0;
    arst_n        = 1'b0;
    req           = '0;
    info_page_sel = 8'h00;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    #1;
    chk("reset valid", 16'(rd_valid), 16'h0000);
    chk("reset region", 16'(region), 16'(PR_NONE));
    t_reg_map();
    t_writes();
    t_program();
    t_info();
    t_b2b();
    wrap_up();
  end

  // the full run needs well under 1000 cycles
  initial
  begin
    repeat (5000) @(posedge mclk);
    err_count++;
    wrap_up();
  end
endmodule
